// ---- core/ppc_pkg.sv ----
// Constants and types shared by the port pad control block
package ppc_pkg;

	// ==========================================================
	// Widths
	localparam int PIN_W = 6;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;

	// ==========================================================
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_PULLUP = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_SLEW = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_DRIVE = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_DIR = 12'h00c;

	// ==========================================================
	// Special pins
	localparam int IN_ONLY_PIN = 5;
	localparam int OUT_ONLY_PIN = 4;

	// ==========================================================
	// Reset values and storage masks
	localparam logic [PIN_W-1:0] CTL_RST = 6'h00;
	localparam logic [PIN_W-1:0] MASK_ALL = 6'h3f;
	localparam logic [PIN_W-1:0] MASK_DIR = 6'h1f;
	localparam logic [PIN_W-1:0] PINS_OFF = 6'h00;

	// ==========================================================
	// Bus slave states
	typedef enum logic {
		PPC_BUS_IDLE,
		PPC_BUS_ANSWER
	} ppc_bus_e;

endpackage : ppc_pkg

// ---- core/ppc_cfg_if.sv ----
// Control bits passed from the register file to the pad logic
`timescale 1ns/1ns
interface ppc_cfg_if;
	logic [ppc_pkg::PIN_W-1:0] pullup_enable_bits;
	logic [ppc_pkg::PIN_W-1:0] slew_enable_bits;
	logic [ppc_pkg::PIN_W-1:0] drive_select_bits;
	logic [ppc_pkg::PIN_W-1:0] direction_bits;

	modport src (
		output pullup_enable_bits,
		output slew_enable_bits,
		output drive_select_bits,
		output direction_bits
	);

	modport dst (
		input pullup_enable_bits,
		input slew_enable_bits,
		input drive_select_bits,
		input direction_bits
	);
endinterface : ppc_cfg_if

// ---- core/ppc_ctl_reg.sv ----
// One six-bit software control register with a storage mask
`timescale 1ns/1ns
module ppc_ctl_reg #(
	parameter logic [ppc_pkg::PIN_W-1:0] MASK = ppc_pkg::MASK_ALL
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic wr_i,
	input wire logic [ppc_pkg::PIN_W-1:0] wdata_i,
	output logic [ppc_pkg::PIN_W-1:0] q_o
);

	// ==========================================================
	// Storage
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q_o <= ppc_pkg::CTL_RST; // R17 R15
		end else if (ce_i && wr_i) begin
			q_o <= wdata_i & MASK; // R17
		end
	end

endmodule : ppc_ctl_reg

// ---- core/ppc_pad_ctl.sv ----
// Per-pin effective pad controls, registered
`timescale 1ns/1ns
module ppc_pad_ctl (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	ppc_cfg_if.dst cfg,
	input wire logic [ppc_pkg::PIN_W-1:0] periph_out_en_i,
	input wire logic [ppc_pkg::PIN_W-1:0] analog_en_i,
	output logic [ppc_pkg::PIN_W-1:0] pad_pullup_o,
	output logic [ppc_pkg::PIN_W-1:0] pad_slew_o,
	output logic [ppc_pkg::PIN_W-1:0] pad_drive_hi_o,
	output logic [ppc_pkg::PIN_W-1:0] pad_drv_en_o
);

	// ==========================================================
	// Output driver decision for one pin
	function automatic logic drives_out(
		input int n,
		input logic dir,
		input logic per,
		input logic ana
	);
		logic r;
		r = dir | per; // R16 R4
		if (n == ppc_pkg::OUT_ONLY_PIN) begin
			r = per; // R11
		end
		if (n == ppc_pkg::IN_ONLY_PIN) begin
			r = 1'b0; // R10 R13 R14
		end
		if (ana) begin
			r = 1'b0;
		end
		return r;
	endfunction : drives_out

	// ==========================================================
	// Pin slices
	for (genvar n = 0; n < ppc_pkg::PIN_W; n++) begin : g_pin
		logic out_w;
		logic pu_ok_w;
		assign out_w = drives_out(n, cfg.direction_bits[n],
			periph_out_en_i[n], analog_en_i[n]);
		assign pu_ok_w = (n != ppc_pkg::OUT_ONLY_PIN); // R12

		always_ff @(posedge clk_i or negedge nrst_i) begin
			if (!nrst_i) begin
				pad_drv_en_o[n] <= 1'b0; // R15
				pad_pullup_o[n] <= 1'b0; // R15
				pad_slew_o[n] <= 1'b0;
				pad_drive_hi_o[n] <= 1'b0;
			end else if (ce_i) begin
				pad_drv_en_o[n] <= out_w; // R16
				pad_pullup_o[n] <= cfg.pullup_enable_bits[n] & ~out_w
					& ~analog_en_i[n] & pu_ok_w; // R2 R3 R4 R5
				pad_slew_o[n] <= cfg.slew_enable_bits[n] & out_w; // R6 R7
				pad_drive_hi_o[n] <= cfg.drive_select_bits[n]
					& out_w; // R8 R9
			end
		end
	end

endmodule : ppc_pad_ctl

// ---- core/ppc_top.sv ----
// Port pad control: APB register file and pad control outputs
//
// Functional notes
// R1: Pad control registers act independently of data and direction storage.
// R2: Every one of six pins has its own pullup enable bit.
// R3: Pullup enable 0 keeps pullup off; 1 turns it on unless overridden.
// R4: Pullup forced off while pin driven by direction bit or peripheral.
// R5: Pullup forced off while an analog function owns the pin.
// R6: Slew bit set limits transition rate of an output pin.
// R7: Slew bit has no effect on an input pin.
// R8: Drive select bit picks low or high drive per pin.
// R9: Drive select bit has no effect on an input pin.
// R10: Input-only pin ignores its direction bit, which always reads zero.
// R11: Output-only pin ignores its direction bit.
// R12: Output-only pin ignores its pullup enable bit.
// R13: Input-only pin ignores its slew bit.
// R14: Input-only pin ignores its drive select bit.
// R15: After reset all pins are inputs with pullups off.
// R16: Direction 1 enables output driver; direction 0 leaves an input.
// R17: Reset clears control bits; upper two bits read zero, ignore writes.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module ppc_top (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ppc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [ppc_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [ppc_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [ppc_pkg::PIN_W-1:0] periph_out_en_i,
	input wire logic [ppc_pkg::PIN_W-1:0] analog_en_i,
	output logic [ppc_pkg::PIN_W-1:0] pad_pullup_o,
	output logic [ppc_pkg::PIN_W-1:0] pad_slew_o,
	output logic [ppc_pkg::PIN_W-1:0] pad_drive_hi_o,
	output logic [ppc_pkg::PIN_W-1:0] pad_drv_en_o
);

	// ==========================================================
	// Address decode
	function automatic logic reg_hit(
		input logic [ppc_pkg::ADDR_W-1:0] addr,
		input logic [ppc_pkg::ADDR_W-1:0] ofs
	);
		return addr == ofs;
	endfunction : reg_hit

	ppc_cfg_if cfg ();

	ppc_pkg::ppc_bus_e state_q;
	logic pready_q;
	logic [ppc_pkg::DATA_W-1:0] prdata_q;
	logic pslverr_q;
	logic access_w;
	logic done_w;
	logic wr_ok_w;
	logic hit_pu_w;
	logic hit_se_w;
	logic hit_ds_w;
	logic hit_dir_w;
	logic mapped_w;
	logic [ppc_pkg::PIN_W-1:0] wbits_w;
	logic [ppc_pkg::DATA_W-1:0] rd_data_w;

	assign access_w = psel_i & penable_i;
	assign done_w = access_w & pready_q;
	assign wr_ok_w = done_w & pwrite_i & pstrb_i[0] & ~pslverr_q;
	assign hit_pu_w = reg_hit(paddr_i, ppc_pkg::OFS_PULLUP);
	assign hit_se_w = reg_hit(paddr_i, ppc_pkg::OFS_SLEW);
	assign hit_ds_w = reg_hit(paddr_i, ppc_pkg::OFS_DRIVE);
	assign hit_dir_w = reg_hit(paddr_i, ppc_pkg::OFS_DIR);
	assign mapped_w = hit_pu_w | hit_se_w | hit_ds_w | hit_dir_w;
	assign wbits_w = pwdata_i[ppc_pkg::PIN_W-1:0]; // R17

	// ==========================================================
	// Bus slave: one wait state, answer then release
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= ppc_pkg::PPC_BUS_IDLE;
			pready_q <= 1'b0;
		end else if (ce_i) begin
			unique case (state_q)
				ppc_pkg::PPC_BUS_IDLE: begin
					if (access_w) begin
						state_q <= ppc_pkg::PPC_BUS_ANSWER;
						pready_q <= 1'b1;
					end
				end
				ppc_pkg::PPC_BUS_ANSWER: begin
					state_q <= ppc_pkg::PPC_BUS_IDLE;
					pready_q <= 1'b0;
				end
			endcase
		end
	end

	// Read data and error captured as the answer is raised
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (ce_i) begin
			if (state_q == ppc_pkg::PPC_BUS_IDLE && access_w) begin
				prdata_q <= pwrite_i ? '0 : rd_data_w;
				pslverr_q <= ~mapped_w;
			end else begin
				prdata_q <= '0;
				pslverr_q <= 1'b0;
			end
		end
	end

	// Read mux, upper bits zero
	always_comb begin
		rd_data_w = '0; // R17
		if (hit_pu_w) begin
			rd_data_w[ppc_pkg::PIN_W-1:0] = cfg.pullup_enable_bits;
		end else if (hit_se_w) begin
			rd_data_w[ppc_pkg::PIN_W-1:0] = cfg.slew_enable_bits;
		end else if (hit_ds_w) begin
			rd_data_w[ppc_pkg::PIN_W-1:0] = cfg.drive_select_bits;
		end else if (hit_dir_w) begin
			rd_data_w[ppc_pkg::PIN_W-1:0] = cfg.direction_bits; // R10
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;

	// ==========================================================
	// Control registers, each written only by its own offset
	ppc_ctl_reg #(.MASK(ppc_pkg::MASK_ALL)) u_pullup (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.wr_i(wr_ok_w & hit_pu_w), // R1 R2
		.wdata_i(wbits_w),
		.q_o(cfg.pullup_enable_bits)
	);

	ppc_ctl_reg #(.MASK(ppc_pkg::MASK_ALL)) u_slew (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.wr_i(wr_ok_w & hit_se_w), // R1 R6
		.wdata_i(wbits_w),
		.q_o(cfg.slew_enable_bits)
	);

	ppc_ctl_reg #(.MASK(ppc_pkg::MASK_ALL)) u_drive (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.wr_i(wr_ok_w & hit_ds_w), // R1 R8
		.wdata_i(wbits_w),
		.q_o(cfg.drive_select_bits)
	);

	// Input-only direction bit is not stored, so it reads zero
	ppc_ctl_reg #(.MASK(ppc_pkg::MASK_DIR)) u_dir (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.wr_i(wr_ok_w & hit_dir_w), // R16 R10
		.wdata_i(wbits_w),
		.q_o(cfg.direction_bits)
	);

	// ==========================================================
	// Pad logic
	ppc_pad_ctl u_pad (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.cfg(cfg),
		.periph_out_en_i(periph_out_en_i),
		.analog_en_i(analog_en_i),
		.pad_pullup_o(pad_pullup_o),
		.pad_slew_o(pad_slew_o),
		.pad_drive_hi_o(pad_drive_hi_o),
		.pad_drv_en_o(pad_drv_en_o)
	);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	AST_PU_NOT_WHEN_DRIVEN: // R4
	assert property ((pad_pullup_o & pad_drv_en_o) == ppc_pkg::PINS_OFF)
		else $error("pullup active on a driven pin");

	AST_PU_NOT_ANALOG: // R5
	assert property (ce_i |=>
		(pad_pullup_o & $past(analog_en_i)) == ppc_pkg::PINS_OFF)
		else $error("pullup active on an analog pin");

	AST_PU_ON: // R2
	assert property (ce_i && cfg.pullup_enable_bits[0]
		&& !cfg.direction_bits[0] && !periph_out_en_i[0]
		&& !analog_en_i[0] |=> pad_pullup_o[0])
		else $error("enabled pullup not applied");

	AST_PU_OFF_BIT: // R3
	assert property (ce_i && !cfg.pullup_enable_bits[1] |=> !pad_pullup_o[1])
		else $error("pullup on with enable bit clear");

	AST_SLEW_OUT_ONLY: // R7
	assert property ((pad_slew_o & ~pad_drv_en_o) == ppc_pkg::PINS_OFF)
		else $error("slew limit on an input pin");

	AST_SLEW_ON: // R6
	assert property (ce_i && cfg.slew_enable_bits[2]
		&& cfg.direction_bits[2] && !analog_en_i[2] |=> pad_slew_o[2])
		else $error("slew limit missing on output");

	AST_DRIVE_OUT_ONLY: // R9
	assert property ((pad_drive_hi_o & ~pad_drv_en_o) == ppc_pkg::PINS_OFF)
		else $error("high drive on an input pin");

	AST_DRIVE_ON: // R8
	assert property (ce_i && cfg.drive_select_bits[3]
		&& cfg.direction_bits[3] && !analog_en_i[3] |=> pad_drive_hi_o[3])
		else $error("high drive missing on output");

	AST_IN_ONLY_PIN: // R10
	assert property (!cfg.direction_bits[ppc_pkg::IN_ONLY_PIN]
		&& !pad_drv_en_o[ppc_pkg::IN_ONLY_PIN])
		else $error("input-only pin direction not zero");

	AST_IN_ONLY_SLEW_DRIVE: // R13 R14
	assert property (!pad_slew_o[ppc_pkg::IN_ONLY_PIN]
		&& !pad_drive_hi_o[ppc_pkg::IN_ONLY_PIN])
		else $error("input-only pin got slew or drive");

	AST_OUT_ONLY_DIR: // R11
	assert property (ce_i && !periph_out_en_i[ppc_pkg::OUT_ONLY_PIN]
		|=> !pad_drv_en_o[ppc_pkg::OUT_ONLY_PIN])
		else $error("output-only pin follows direction bit");

	AST_OUT_ONLY_PU: // R12
	assert property (!pad_pullup_o[ppc_pkg::OUT_ONLY_PIN])
		else $error("output-only pin pullup active");

	AST_DIR_DRIVES: // R16
	assert property (ce_i && cfg.direction_bits[0] && !analog_en_i[0]
		|=> pad_drv_en_o[0])
		else $error("direction bit did not enable driver");

	AST_WRITE_TAKES: // R17
	assert property (wr_ok_w && hit_se_w && ce_i |=>
		cfg.slew_enable_bits == $past(wbits_w))
		else $error("control write not stored");

	AST_INDEPENDENT: // R1
	assert property (wr_ok_w && !hit_dir_w |=> $stable(cfg.direction_bits))
		else $error("control write changed direction bits");

	AST_UPPER_ZERO: // R17
	assert property (prdata_o[ppc_pkg::DATA_W-1:ppc_pkg::PIN_W] == '0)
		else $error("upper read bits not zero");

	AST_ANSWER_TIME:
	assert property (ce_i && access_w && !pready_q |=> pready_q)
		else $error("answer not raised after one cycle");

	AST_RESET_STATE: // R15
	assert property ($rose(nrst_i) |-> pad_drv_en_o == ppc_pkg::PINS_OFF
		&& pad_pullup_o == ppc_pkg::PINS_OFF)
		else $error("pins not inputs after reset");

	AST_FREEZE:
	assert property (!ce_i |=> $stable(pad_drv_en_o)
		&& $stable(pad_pullup_o) && $stable(pad_slew_o)
		&& $stable(pad_drive_hi_o))
		else $error("pads changed while clock disabled");

	AST_PREADY_PULSE:
	assert property (ce_i && pready_o |=> !pready_o)
		else $error("answer stood longer than one cycle");

	AST_QUIET_IDLE:
	assert property (!pready_o |-> prdata_o == '0 && !pslverr_o)
		else $error("read data or error outside an answer");

	AST_ERR_NO_WRITE:
	assert property (done_w && pslverr_q |=>
		$stable(cfg.pullup_enable_bits) && $stable(cfg.slew_enable_bits)
		&& $stable(cfg.drive_select_bits) && $stable(cfg.direction_bits))
		else $error("unmapped write changed a register");

	COV_WRITE: cover property (wr_ok_w && hit_pu_w);
	COV_READ: cover property (done_w && !pwrite_i && hit_dir_w);
	COV_ERR: cover property (done_w && pslverr_q);
	COV_PU_KILLED: cover property (cfg.pullup_enable_bits[0]
		&& pad_drv_en_o[0]);
	COV_FREEZE: cover property (!ce_i && pad_drv_en_o != ppc_pkg::PINS_OFF);

endmodule : ppc_top

// ---- verification/ppc_pad_model.sv ----
// Far-side model: shared peripheral and analog owners of the port pins
`timescale 1ns/1ns
module ppc_pad_model (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [5:0] per_req_i,
	input wire logic [5:0] ana_req_i,
	output logic [5:0] periph_out_en_o,
	output logic [5:0] analog_en_o
);
	// ==========================================================
	// Peripherals come up disabled and switch on a clock edge
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			periph_out_en_o <= 6'h00;
			analog_en_o <= 6'h00;
		end else begin
			periph_out_en_o <= per_req_i;
			analog_en_o <= ana_req_i;
		end
	end
endmodule : ppc_pad_model

// ---- verification/testbench.sv ----
// Self-checking testbench for the port pad control block
`timescale 1ns/1ns
module testbench;
	logic clk_i, nrst_i, ce_i, psel_i, penable_i, pwrite_i, pready_o;
	logic pslverr_o, er;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [3:0] pstrb_i;
	logic [5:0] per_req, ana_req, periph_out_en_i, analog_en_i;
	logic [5:0] pad_pullup_o, pad_slew_o, pad_drive_hi_o, pad_drv_en_o;
	int n_errors = 0;
	int n_checks = 0;

	ppc_top dut (.clk_i, .nrst_i, .ce_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
		.periph_out_en_i, .analog_en_i, .pad_pullup_o, .pad_slew_o,
		.pad_drive_hi_o, .pad_drv_en_o);
	ppc_pad_model pm (.clk_i, .nrst_i, .per_req_i(per_req),
		.ana_req_i(ana_req), .periph_out_en_o(periph_out_en_i),
		.analog_en_o(analog_en_i));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// ==========================================================
	// Shared tasks
	task summarize();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= s;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50)
			chk("pready", {31'h0, pready_o}, 32'h1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(nm, rd, e);
	endtask : rdc

	// Pads settle two edges after a request: model stage then pad stage
	task pads(input logic [5:0] pu, sl, dr, en);
		repeat (4) @(posedge clk_i);
		chk("pullup", {26'h0, pad_pullup_o}, {26'h0, pu});
		chk("slew", {26'h0, pad_slew_o}, {26'h0, sl});
		chk("drive", {26'h0, pad_drive_hi_o}, {26'h0, dr});
		chk("drv_en", {26'h0, pad_drv_en_o}, {26'h0, en});
	endtask : pads

	// ==========================================================
	// Scenarios
	task t_reset();
		rdc("pu_rst", ppc_pkg::OFS_PULLUP, 32'h0);
		rdc("se_rst", ppc_pkg::OFS_SLEW, 32'h0);
		rdc("ds_rst", ppc_pkg::OFS_DRIVE, 32'h0);
		rdc("dir_rst", ppc_pkg::OFS_DIR, 32'h0);
		pads(6'h00, 6'h00, 6'h00, 6'h00);
	endtask : t_reset

	task t_regs();
		apb(1'b1, ppc_pkg::OFS_PULLUP, 32'hffffffff, 4'hf);
		rdc("pu_rw", ppc_pkg::OFS_PULLUP, 32'h3f);
		apb(1'b1, ppc_pkg::OFS_DIR, 32'hffffffff, 4'hf);
		rdc("dir_rw", ppc_pkg::OFS_DIR, 32'h1f);
		apb(1'b1, ppc_pkg::OFS_SLEW, 32'h3f, 4'h0);
		rdc("se_nostrb", ppc_pkg::OFS_SLEW, 32'h0);
		apb(1'b0, 12'h010, 32'h0, 4'h0);
		chk("unmapped_err", {31'h0, er}, 32'h1);
		chk("unmapped_rd", rd, 32'h0);
		apb(1'b1, ppc_pkg::OFS_DIR, 32'h0, 4'hf);
	endtask : t_regs

	task t_pullup();
		pads(6'h2f, 6'h00, 6'h00, 6'h00);
		apb(1'b1, ppc_pkg::OFS_DIR, 32'h3, 4'hf);
		pads(6'h2c, 6'h00, 6'h00, 6'h03);
		per_req <= 6'h04;
		pads(6'h28, 6'h00, 6'h00, 6'h07);
		ana_req <= 6'h09;
		pads(6'h20, 6'h00, 6'h00, 6'h06);
		per_req <= 6'h00;
		ana_req <= 6'h00;
		apb(1'b1, ppc_pkg::OFS_DIR, 32'h0, 4'hf);
	endtask : t_pullup

	task t_slew_drive();
		apb(1'b1, ppc_pkg::OFS_SLEW, 32'h3f, 4'hf);
		apb(1'b1, ppc_pkg::OFS_DRIVE, 32'h3f, 4'hf);
		pads(6'h2f, 6'h00, 6'h00, 6'h00);
		apb(1'b1, ppc_pkg::OFS_DIR, 32'h3f, 4'hf);
		pads(6'h20, 6'h0f, 6'h0f, 6'h0f);
		rdc("dir_keep", ppc_pkg::OFS_DIR, 32'h1f);
		per_req <= 6'h10;
		pads(6'h20, 6'h1f, 6'h1f, 6'h1f);
		ana_req <= 6'h01;
		pads(6'h20, 6'h1e, 6'h1e, 6'h1e);
		apb(1'b1, ppc_pkg::OFS_DRIVE, 32'h05, 4'hf);
		pads(6'h20, 6'h1e, 6'h04, 6'h1e);
	endtask : t_slew_drive

	// Clock enable low holds the pads although the far side moves
	task t_freeze();
		ce_i <= 1'b0;
		per_req <= 6'h00;
		ana_req <= 6'h00;
		pads(6'h20, 6'h1e, 6'h04, 6'h1e);
		ce_i <= 1'b1;
		pads(6'h20, 6'h0f, 6'h05, 6'h0f);
	endtask : t_freeze

	// Second reset in mid-run clears every control bit again
	task t_mid_reset();
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		rdc("pu_rst2", ppc_pkg::OFS_PULLUP, 32'h0);
		rdc("se_rst2", ppc_pkg::OFS_SLEW, 32'h0);
		rdc("ds_rst2", ppc_pkg::OFS_DRIVE, 32'h0);
		rdc("dir_rst2", ppc_pkg::OFS_DIR, 32'h0);
		pads(6'h00, 6'h00, 6'h00, 6'h00);
	endtask : t_mid_reset

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		nrst_i = 1'b0;
		ce_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		pstrb_i = 4'h0;
		per_req = 6'h00;
		ana_req = 6'h00;
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_regs();
		t_pullup();
		t_slew_drive();
		t_freeze();
		t_mid_reset();
		summarize();
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		summarize();
	end
endmodule : testbench
